// ### rtl/pcr_pkg.sv
package pcr_pkg;

  // Register port geometry
  localparam int          PCR_ADDR_W        = 16;
  localparam int          PCR_DATA_W        = 8;
  localparam int          PCR_NUM_LOOPS     = 2;

  // Register offsets
  localparam logic [15:0] PCR_OFS_UPDATE    = 16'h000F;
  localparam logic [15:0] PCR_OFS_GATE      = 16'h0FFF;
  localparam logic [15:0] PCR_OFS_LOOP_ONE  = 16'h1588;
  localparam logic [15:0] PCR_OFS_LOOP_TWO  = 16'h1688;
  localparam logic [15:0] PCR_OFS_STATUS    = 16'h1690;

  // Key values
  localparam logic [7:0]  PCR_GATE_UNLOCK   = 8'hF9;
  localparam logic [7:0]  PCR_GATE_RESET    = 8'h00;
  localparam logic [7:0]  PCR_UPDATE_CMD    = 8'h01;
  localparam logic [7:0]  PCR_READ_ZERO     = 8'h00;

  // Calibration register fields
  localparam int          PCR_EN_BIT        = 0;
  localparam int          PCR_LEVEL_LSB     = 1;
  localparam int          PCR_LEVEL_MSB     = 2;
  localparam int          PCR_FIELD_W       = 3;
  localparam logic [1:0]  PCR_LEVEL_RESET   = 2'h0;
  localparam logic        PCR_EN_RESET      = 1'b0;

  // Status register fields
  localparam int          PCR_ST_PEND_LSB   = 0;
  localparam int          PCR_ST_REWR_LSB   = 2;
  localparam int          PCR_ST_BLOCK_BIT  = 4;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [15:0]           addr;
    logic [7:0]            wdata;
  } pcr_bus_req_t;

  typedef struct packed {
    logic                  manual_en;
    logic [1:0]            level;
    logic [1:0]            applied_level;
  } pcr_loop_cfg_t;

endpackage

// ### rtl/pcr_cal_reg.sv
`timescale 1ns/100ps
`default_nettype none

module pcr_cal_reg
  import pcr_pkg::*;
(
  // Clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   sys_rst_in,
  // Control from the bank
  input  wire logic                   wr_en_in,
  input  wire logic [2:0]             wdata_in,
  input  wire logic                   update_in,
  // State
  output logic      [2:0]             staged_out,
  output logic                        rewrite_out,
  output pcr_pkg::pcr_loop_cfg_t      cfg_out
);
  import pcr_pkg::*;

  typedef struct packed {
    logic [2:0]    staged;
    logic          written;
    logic          rewrite;
    pcr_loop_cfg_t cfg;
  } pcr_cal_state_t;

  pcr_cal_state_t state_q;
  pcr_cal_state_t state_d;

  always_comb
  begin
    state_d         = state_q;
    state_d.rewrite = 1'b0;
    if (wr_en_in)
    begin
      // Only bits [2:0] are stored, so reserved bits read back as zero
      state_d.staged  = wdata_in;
      state_d.written = 1'b1;
      // A second write in one power cycle is taken but reported
      state_d.rewrite = state_q.written;
    end
    if (update_in)
    begin
      // Staged value becomes live only on the update strobe
      state_d.cfg.manual_en = state_q.staged[PCR_EN_BIT];
      state_d.cfg.level     = state_q.staged[PCR_LEVEL_MSB:PCR_LEVEL_LSB];
      state_d.cfg.applied_level = state_q.staged[PCR_EN_BIT] ?
                                  state_q.staged[PCR_LEVEL_MSB:PCR_LEVEL_LSB] :
                                  PCR_LEVEL_RESET;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= '{staged: {PCR_LEVEL_RESET, PCR_EN_RESET}, written: 1'b0, rewrite: 1'b0,
                   cfg: '{manual_en: PCR_EN_RESET, level: PCR_LEVEL_RESET,
                          applied_level: PCR_LEVEL_RESET}};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign staged_out  = state_q.staged;
  assign rewrite_out = state_q.rewrite;
  assign cfg_out     = state_q.cfg;

endmodule // pcr_cal_reg

`default_nettype wire

// ### rtl/pcr_cal_bank.sv
`timescale 1ns/100ps
`default_nettype none

module pcr_cal_bank
  import pcr_pkg::*;
#(
  parameter int NUM_LOOPS = PCR_NUM_LOOPS
)
(
  // Clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   sys_rst_in,
  // Register port
  input  wire pcr_pkg::pcr_bus_req_t  bus_req_in,
  output logic [7:0]                  bus_rdata_out,
  // Live calibration settings, one per analog loop
  output pcr_pkg::pcr_loop_cfg_t      analog_loop_one_out,
  output pcr_pkg::pcr_loop_cfg_t      analog_loop_two_out
);
  import pcr_pkg::*;

  localparam logic [15:0] LOOP_OFS [PCR_NUM_LOOPS] = '{PCR_OFS_LOOP_ONE, PCR_OFS_LOOP_TWO};

  typedef struct packed {
    logic [7:0]           gate;
    logic [NUM_LOOPS-1:0] rewrite;
    logic                 blocked;
    logic [7:0]           rdata;
  } pcr_bank_state_t;

  pcr_bank_state_t      state_q;
  pcr_bank_state_t      state_d;

  logic                 unlocked;
  logic                 update;
  logic                 cal_hit;
  logic [NUM_LOOPS-1:0] loop_wr;
  logic [NUM_LOOPS-1:0] loop_sel;
  logic [NUM_LOOPS-1:0] loop_rewrite;
  logic [NUM_LOOPS-1:0] loop_pending;
  logic [2:0]           staged   [NUM_LOOPS];
  pcr_loop_cfg_t        loop_cfg [NUM_LOOPS];

  // Gate open only on the exact unlock value
  assign unlocked = (state_q.gate == PCR_GATE_UNLOCK);
  // Other values written to the update register do nothing
  assign update   = bus_req_in.wr && (bus_req_in.addr == PCR_OFS_UPDATE)
                    && (bus_req_in.wdata == PCR_UPDATE_CMD);

  genvar g;
  generate
    for (g = 0; g < NUM_LOOPS; g++)
    begin : g_loop
      assign loop_sel[g] = (bus_req_in.addr == LOOP_OFS[g]);
      assign loop_wr[g]  = bus_req_in.wr && loop_sel[g] && unlocked;
      assign loop_pending[g] = (staged[g] != {loop_cfg[g].level, loop_cfg[g].manual_en});

      pcr_cal_reg u_cal_reg
      (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (loop_wr[g]),
        .wdata_in    (bus_req_in.wdata[PCR_FIELD_W-1:0]),
        .update_in   (update),
        .staged_out  (staged[g]),
        .rewrite_out (loop_rewrite[g]),
        .cfg_out     (loop_cfg[g])
      );
    end
  endgenerate

  assign cal_hit = |loop_sel;

  always_comb
  begin
    state_d       = state_q;
    state_d.rdata = PCR_READ_ZERO;

    if (bus_req_in.wr && (bus_req_in.addr == PCR_OFS_GATE))
    begin
      state_d.gate = bus_req_in.wdata;
    end

    // Status sticky bits clear on writing one; a fresh event wins
    if (bus_req_in.wr && (bus_req_in.addr == PCR_OFS_STATUS))
    begin
      state_d.rewrite = state_q.rewrite
                        & ~bus_req_in.wdata[PCR_ST_REWR_LSB +: NUM_LOOPS];
      state_d.blocked = state_q.blocked & ~bus_req_in.wdata[PCR_ST_BLOCK_BIT];
    end
    state_d.rewrite = state_d.rewrite | loop_rewrite;
    // A calibration write refused by the gate leaves a trace for software
    if (bus_req_in.wr && cal_hit && !unlocked)
    begin
      state_d.blocked = 1'b1;
    end

    if (bus_req_in.rd)
    begin
      if (bus_req_in.addr == PCR_OFS_GATE)
      begin
        state_d.rdata = state_q.gate;
      end
      else if (bus_req_in.addr == PCR_OFS_STATUS)
      begin
        state_d.rdata[PCR_ST_PEND_LSB +: NUM_LOOPS] = loop_pending;
        state_d.rdata[PCR_ST_REWR_LSB +: NUM_LOOPS] = state_q.rewrite;
        state_d.rdata[PCR_ST_BLOCK_BIT]             = state_q.blocked;
      end
      else
      begin
        for (int i = 0; i < NUM_LOOPS; i++)
        begin
          if (loop_sel[i])
          begin
            // Reads return the staged copy with reserved bits zero
            state_d.rdata[PCR_FIELD_W-1:0] = staged[i];
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= '{gate: PCR_GATE_RESET, rewrite: '0, blocked: 1'b0,
                   rdata: PCR_READ_ZERO};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign bus_rdata_out       = state_q.rdata;
  assign analog_loop_one_out = loop_cfg[0];
  assign analog_loop_two_out = loop_cfg[1];

endmodule // pcr_cal_bank

`default_nettype wire

// ### verif/pcr_cal_bank_sva.sv
`timescale 1ns/100ps
`default_nettype none
module pcr_cal_bank_sva
  import pcr_pkg::*;
#(
  parameter int NUM_LOOPS = PCR_NUM_LOOPS
)
(
  // Clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   sys_rst_in,
  // Observed ports
  input  wire pcr_pkg::pcr_bus_req_t  bus_req_in,
  input  wire logic [7:0]             bus_rdata_out,
  input  wire pcr_pkg::pcr_loop_cfg_t analog_loop_one_out,
  input  wire pcr_pkg::pcr_loop_cfg_t analog_loop_two_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic upd;
  assign upd = bus_req_in.wr && bus_req_in.addr == PCR_OFS_UPDATE
               && bus_req_in.wdata == PCR_UPDATE_CMD;
  sequence s_cal_rd;
    bus_req_in.rd && (bus_req_in.addr == PCR_OFS_LOOP_ONE || bus_req_in.addr == PCR_OFS_LOOP_TWO);
  endsequence
  a_rdata_idle_zero: assert property (!bus_req_in.rd |=> bus_rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  a_rsvd_bits_zero: assert property (s_cal_rd |=> bus_rdata_out[7:3] == 5'h00)
    else $error("reserved bits read nonzero");
  a_one_applied_level: assert property (analog_loop_one_out.applied_level ==
    (analog_loop_one_out.manual_en ? analog_loop_one_out.level : 2'h0))
    else $error("loop one applied level wrong");
  a_two_applied_level: assert property (analog_loop_two_out.applied_level ==
    (analog_loop_two_out.manual_en ? analog_loop_two_out.level : 2'h0))
    else $error("loop two applied level wrong");
  a_one_live_held: assert property (!upd |=> $stable(analog_loop_one_out))
    else $error("loop one changed without update");
  a_two_live_held: assert property (!upd |=> $stable(analog_loop_two_out))
    else $error("loop two changed without update");
endmodule // pcr_cal_bank_sva

bind pcr_cal_bank pcr_cal_bank_sva #(.NUM_LOOPS(NUM_LOOPS)) chk_u (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .bus_req_in(bus_req_in),
  .bus_rdata_out(bus_rdata_out), .analog_loop_one_out(analog_loop_one_out),
  .analog_loop_two_out(analog_loop_two_out));
`default_nettype wire

// ### verif/pcr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pcr_host_model
  import pcr_pkg::*;
(
  // Clock
  input  wire logic                  core_clk_in,
  // Register port
  output var pcr_pkg::pcr_bus_req_t  bus_req_out,
  input  wire logic [7:0]            bus_rdata_in
);
  initial bus_req_out = '0;
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    bus_req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_in);
    bus_req_out <= '0;
  endtask
  // Read data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    bus_req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_in);
    bus_req_out <= '0;
    #1 d = bus_rdata_in;
  endtask
  task automatic gate(input logic [7:0] key);
    wr(PCR_OFS_GATE, key);
  endtask
  task automatic update();
    wr(PCR_OFS_UPDATE, PCR_UPDATE_CMD);
  endtask
endmodule // pcr_host_model
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pcr_pkg::*;
  logic          core_clk_in = 1'b0;
  logic          sys_rst_in  = 1'b1;
  pcr_bus_req_t  req;
  logic [7:0]    rdata;
  pcr_loop_cfg_t one;
  pcr_loop_cfg_t two;
  logic [7:0]    d;
  int            miscompares = 0;
  int            n_compared  = 0;
  always #5 core_clk_in = ~core_clk_in;
  pcr_cal_bank dut_u (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .bus_req_in(req),
    .bus_rdata_out(rdata), .analog_loop_one_out(one), .analog_loop_two_out(two));
  pcr_host_model host_u (.core_clk_in(core_clk_in), .bus_req_out(req), .bus_rdata_in(rdata));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk("readback", e, d);
  endtask
  task automatic cfg(input logic [4:0] e1, input logic [4:0] e2);
    #1;
    chk("loop one", {3'h0, e1}, {3'h0, one});
    chk("loop two", {3'h0, e2}, {3'h0, two});
  endtask
  task automatic do_reset();
    sys_rst_in <= 1'b1;
    repeat (5) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
  endtask
  task automatic test_done();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    do_reset();
    cfg(5'h00, 5'h00);
    rchk(PCR_OFS_LOOP_ONE, 8'h00);
    host_u.wr(PCR_OFS_LOOP_ONE, 8'h03);
    rchk(PCR_OFS_LOOP_ONE, 8'h00);
    host_u.gate(8'hF8);
    host_u.wr(PCR_OFS_LOOP_TWO, 8'h03);
    rchk(PCR_OFS_LOOP_TWO, 8'h00);
    rchk(PCR_OFS_GATE, 8'hF8);
    rchk(PCR_OFS_STATUS, 8'h10);
    host_u.wr(PCR_OFS_STATUS, 8'h10);
    rchk(PCR_OFS_STATUS, 8'h00);
    host_u.gate(PCR_GATE_UNLOCK);
    host_u.wr(PCR_OFS_LOOP_ONE, 8'hFB);
    host_u.wr(PCR_OFS_LOOP_TWO, 8'h05);
    host_u.gate(PCR_GATE_RESET);
    rchk(PCR_OFS_GATE, 8'h00);
    rchk(PCR_OFS_STATUS, 8'h03);
    rchk(PCR_OFS_LOOP_ONE, 8'h03);
    rchk(PCR_OFS_LOOP_TWO, 8'h05);
    cfg(5'h00, 5'h00);
    // Only the exact update code moves staged values to the live copy
    host_u.wr(PCR_OFS_UPDATE, 8'h02);
    cfg(5'h00, 5'h00);
    host_u.update();
    cfg(5'h15, 5'h1A);
    rchk(PCR_OFS_STATUS, 8'h00);
    // Power cycle between passes so each of the 8 staged values is programmed once
    for (int i = 0; i < 8; i++)
    begin
      do_reset();
      host_u.gate(PCR_GATE_UNLOCK);
      host_u.wr(PCR_OFS_LOOP_TWO, 8'(i));
      host_u.gate(PCR_GATE_RESET);
      host_u.update();
      cfg(5'h00, {i[0], i[2:1], i[0] ? i[2:1] : 2'h0});
    end
    test_done();
  end
  initial
  begin
    #100000;
    miscompares++;
    test_done();
  end
endmodule // tb
`default_nettype wire
